// File: logic/frd_core.sv
// Command sequencer for deleted-data reads and ID reads
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module frd_core (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             cyc_i,
	input  wire logic             stb_i,
	input  wire logic             we_i,
	input  wire logic [5:2]       adr_i,
	input  wire logic [3:0]       sel_i,
	input  wire logic [31:0]      dat_i,
	output logic      [31:0]      dat_o,
	output logic                  ack_o,
	input  wire logic             indexPulse,
	input  wire logic             hdrValid,
	input  wire frd_pkg::frd_id_s hdr,
	input  wire logic             hdrCrcErr,
	input  wire logic             dataFound,
	input  wire logic             dataDeleted,
	input  wire logic             dataMissing,
	input  wire logic             sectorDone,
	input  wire logic             dataCrcErr,
	input  wire logic             overrun,
	input  wire logic             transferEndStrobe,
	output logic                  separatorOn,
	output logic                  sectorRead,
	output logic                  dmaMode,
	output logic      [7:0]       driveOutput,
	output logic                  irqReq
);
	frd_pkg::frd_state_e stateQ, stateD;
	logic [7:0]       cmdQ [0:8];
	logic [7:0]       resQ [0:6];
	logic [3:0]       cmdCntQ;
	logic [2:0]       resIdxQ, resLenQ;
	logic [15:0]      delayCntQ;
	logic [7:0]       drvOutQ, cfgQ, fbQ, fcQ, fbSet, fcSet, rdMux;
	logic             headBitQ, stopQ, endStbQ, seenIdQ, twoIdx;
	logic             access, wrData, rdData, isRid, isExec;
	logic             doFin, advance;
	logic [1:0]       termD;
	logic [2:0]       lenD;
	frd_pkg::frd_id_s curQ, nxtId, idSel;

	// Opcode match under a mask
	function automatic logic opMatch(input logic [7:0] b,
		input logic [7:0] pat, input logic [7:0] msk);
		return (b & msk) == pat;
	endfunction : opMatch

	// Bus access decode; effects happen once, in the request cycle before ack rises
	assign access = cyc_i && stb_i && !ack_o;
	assign wrData = access && we_i && sel_i[0] && adr_i == frd_pkg::IDX_FIFO;
	assign rdData = access && !we_i && adr_i == frd_pkg::IDX_FIFO;
	assign isRid  = opMatch(cmdQ[0], frd_pkg::OPC_RID, frd_pkg::OPC_RID_MASK);
	assign isExec = stateQ inside {frd_pkg::ST_DELAY, frd_pkg::ST_SEARCH,
		frd_pkg::ST_DWAIT, frd_pkg::ST_READ, frd_pkg::ST_ADV};

	frd_next_id u_next (
		.multiTrack (cmdQ[0][frd_pkg::OP_MULTI_TRACK]),
		.headBit    (headBitQ),
		.lastSector (cmdQ[frd_pkg::CB_LAST]),
		.cur        (curQ),
		.nxt        (nxtId)
	);

	frd_index_watch u_index (
		.clk_sys    (clk_sys),
		.rst        (rst),
		.clear      (stateQ != frd_pkg::ST_SEARCH),
		.indexPulse (indexPulse),
		.twoSeen    (twoIdx)
	);

	// Phase sequencing and termination decisions
	always_comb begin
		stateD  = stateQ;
		doFin   = 1'h0;
		advance = 1'h0;
		termD   = frd_pkg::TERM_ABNORMAL;
		lenD    = frd_pkg::RES_LEN;
		fbSet   = 8'h00;
		fcSet   = 8'h00;
		idSel   = curQ;
		case (stateQ)
			frd_pkg::ST_IDLE: begin
				if (wrData) begin
					if (opMatch(dat_i[7:0], frd_pkg::OPC_RDD,
						frd_pkg::OPC_RDD_MASK) || opMatch(dat_i[7:0],
						frd_pkg::OPC_RID, frd_pkg::OPC_RID_MASK)) begin
						stateD = frd_pkg::ST_CMD;
					end else begin
						doFin = 1'h1;
						termD = frd_pkg::TERM_INVALID;
						lenD  = frd_pkg::BAD_LEN;
					end
				end
			end
			frd_pkg::ST_CMD: begin
				if (wrData && cmdCntQ == (isRid ? frd_pkg::RID_LAST :
					frd_pkg::RDD_LAST)) begin
					// Read-ID never seeks and always waits first
					stateD = isRid ? frd_pkg::ST_DELAY :
						frd_pkg::ST_SEARCH;
				end
			end
			frd_pkg::ST_DELAY: begin
				if (wrData) begin
					doFin = 1'h1;
				end else if (delayCntQ ==
					16'(frd_pkg::PRE_CYC - 1)) begin
					stateD = frd_pkg::ST_SEARCH;
				end
			end
			frd_pkg::ST_SEARCH: begin
				if (wrData) begin
					doFin = 1'h1;
				end else if (hdrValid) begin
					if (hdrCrcErr) begin
						doFin = 1'h1;
						fbSet[frd_pkg::FB_CRC] = 1'h1;
					end else if (isRid) begin
						doFin = 1'h1;
						termD = frd_pkg::TERM_NORMAL;
						idSel = hdr;
					end else if (hdr == curQ) begin
						stateD = frd_pkg::ST_DWAIT;
					end
				end else if (twoIdx) begin
					doFin = 1'h1;
					if (seenIdQ && !isRid) begin
						fbSet[frd_pkg::FB_NO_DATA] = 1'h1;
					end else begin
						fbSet[frd_pkg::FB_MISS_MRK] = 1'h1;
					end
				end
			end
			frd_pkg::ST_DWAIT: begin
				if (wrData) begin
					doFin = 1'h1;
				end else if (dataMissing) begin
					doFin = 1'h1;
					fbSet[frd_pkg::FB_MISS_MRK] = 1'h1;
				end else if (dataFound) begin
					if (!dataDeleted && cmdQ[0][frd_pkg::OP_BYPASS]) begin
						stateD = frd_pkg::ST_ADV;
					end else begin
						stateD = frd_pkg::ST_READ;
					end
				end
			end
			frd_pkg::ST_READ: begin
				if (wrData) begin
					doFin = 1'h1;
				end else if (sectorDone) begin
					if (dataCrcErr) begin
						doFin = 1'h1;
						fbSet[frd_pkg::FB_CRC] = 1'h1;
						fcSet[frd_pkg::FC_DATA_CRC] = 1'h1;
					end else if (overrun) begin
						doFin = 1'h1;
						fbSet[frd_pkg::FB_OVERRUN] = 1'h1;
					end else begin
						stateD = frd_pkg::ST_ADV;
					end
				end
			end
			frd_pkg::ST_ADV: begin
				if (wrData) begin
					doFin = 1'h1;
				end else if (endStbQ || stopQ) begin
					doFin = 1'h1;
					termD = frd_pkg::TERM_NORMAL;
					idSel = nxtId;
				end else if (curQ.sector == cmdQ[frd_pkg::CB_LAST] &&
					!(cmdQ[0][frd_pkg::OP_MULTI_TRACK] && !headBitQ)) begin
					doFin = 1'h1;
					fbSet[frd_pkg::FB_END_TRK] = 1'h1;
					idSel = nxtId;
				end else begin
					stateD  = frd_pkg::ST_SEARCH;
					advance = 1'h1;
				end
			end
			frd_pkg::ST_RESULT: begin
				if (rdData && resIdxQ == resLenQ - 3'h1) begin
					stateD = frd_pkg::ST_IDLE;
				end
			end
			default: stateD = frd_pkg::ST_IDLE;
		endcase
		if (doFin) begin
			stateD = frd_pkg::ST_RESULT;
		end
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			stateQ <= frd_pkg::ST_IDLE;
		end else begin
			stateQ <= stateD;
		end
	end

	// Command byte capture
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cmdCntQ <= 4'h0;
			for (int i = 0; i < 9; i++) begin
				cmdQ[i] <= 8'h00;
			end
		end else if (wrData && stateQ == frd_pkg::ST_IDLE) begin
			cmdQ[0] <= dat_i[7:0];
			cmdCntQ <= 4'h1;
		end else if (wrData && stateQ == frd_pkg::ST_CMD) begin
			cmdQ[cmdCntQ] <= dat_i[7:0];
			cmdCntQ       <= cmdCntQ + 4'h1;
		end
	end

	// Current sector ID and multi-track side tracking
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			curQ     <= '0;
			headBitQ <= 1'h0;
		end else if (stateQ == frd_pkg::ST_CMD) begin
			curQ.track  <= cmdQ[frd_pkg::CB_TRACK];
			curQ.head   <= cmdQ[frd_pkg::CB_HEAD];
			curQ.sector <= cmdQ[frd_pkg::CB_SECT];
			curQ.size   <= cmdQ[frd_pkg::CB_SIZE];
			headBitQ    <= cmdQ[1][frd_pkg::SEL_HEAD];
		end else if (advance) begin
			if (curQ.sector == cmdQ[frd_pkg::CB_LAST]) begin
				curQ.head   <= 8'h01;
				curQ.sector <= 8'h01;
				headBitQ    <= 1'h1;
			end else begin
				curQ.sector <= curQ.sector + 8'h01;
			end
		end
	end

	// Execution flags: control mark, stop, transfer end, headers seen
	always_ff @(posedge clk_sys) begin
		if (rst || stateQ == frd_pkg::ST_CMD) begin
			fbQ     <= 8'h00;
			fcQ     <= 8'h00;
			stopQ   <= 1'h0;
			endStbQ <= 1'h0;
			seenIdQ <= 1'h0;
		end else begin
			if (stateQ == frd_pkg::ST_DWAIT && dataFound && !dataDeleted) begin
				fcQ[frd_pkg::FC_CTRL_MRK] <= 1'h1;
				stopQ <= !cmdQ[0][frd_pkg::OP_BYPASS];
			end
			if (stateQ == frd_pkg::ST_READ && transferEndStrobe) begin
				endStbQ <= 1'h1;
			end
			if (stateQ == frd_pkg::ST_SEARCH && hdrValid) begin
				seenIdQ <= 1'h1;
			end
		end
	end

	// Pre-processing delay counter
	always_ff @(posedge clk_sys) begin
		if (rst || stateQ != frd_pkg::ST_DELAY) begin
			delayCntQ <= 16'h0000;
		end else begin
			delayCntQ <= delayCntQ + 16'h0001;
		end
	end

	// Result bytes loaded at termination, popped by host reads
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			resIdxQ <= 3'h0;
			resLenQ <= 3'h0;
			for (int i = 0; i < 7; i++) begin
				resQ[i] <= 8'h00;
			end
		end else if (doFin) begin
			resIdxQ <= 3'h0;
			resLenQ <= lenD;
			resQ[0] <= (termD == frd_pkg::TERM_INVALID) ? {termD, 6'h00} :
				{termD, 3'h0, headBitQ, cmdQ[1][1:0]};
			resQ[1] <= fbQ | fbSet;
			resQ[2] <= fcQ | fcSet;
			resQ[3] <= idSel.track;
			resQ[4] <= idSel.head;
			resQ[5] <= idSel.sector;
			resQ[6] <= idSel.size;
		end else if (rdData && stateQ == frd_pkg::ST_RESULT) begin
			resIdxQ <= resIdxQ + 3'h1;
		end
	end

	// Interrupt request from result start to first result read
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irqReq <= 1'h0;
		end else if (doFin) begin
			irqReq <= 1'h1;
		end else if (rdData && stateQ == frd_pkg::ST_RESULT) begin
			irqReq <= 1'h0;
		end
	end

	// Software registers: drive outputs and transfer configuration
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			drvOutQ <= frd_pkg::DRV_OUT_RST;
			cfgQ    <= frd_pkg::CONFIG_RST;
		end else if (access && we_i && sel_i[0]) begin
			if (adr_i == frd_pkg::IDX_DRV_OUT) begin
				drvOutQ <= dat_i[7:0];
			end else if (adr_i == frd_pkg::IDX_CONFIG) begin
				cfgQ <= dat_i[7:0];
			end
		end
	end

	// Read data selection
	always_comb begin
		rdMux = 8'h00;
		if (adr_i == frd_pkg::IDX_DRV_OUT) begin
			rdMux = drvOutQ;
		end else if (adr_i == frd_pkg::IDX_CONFIG) begin
			rdMux = cfgQ;
		end else if (adr_i == frd_pkg::IDX_STATUS) begin
			rdMux[frd_pkg::SR_READY]   = !isExec;
			rdMux[frd_pkg::SR_TO_HOST] = stateQ == frd_pkg::ST_RESULT;
			rdMux[frd_pkg::SR_EXEC]    = isExec;
			rdMux[frd_pkg::SR_BUSY]    = stateQ != frd_pkg::ST_IDLE;
			rdMux[frd_pkg::SR_IRQ]     = irqReq;
		end else if (adr_i == frd_pkg::IDX_FIFO &&
			stateQ == frd_pkg::ST_RESULT) begin
			rdMux = resQ[resIdxQ];
		end
	end

	// Bus answer one cycle after the request, data registered
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ack_o <= 1'h0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= access;
			dat_o <= (access && !we_i) ? {24'h000000, rdMux} : 32'h0000_0000;
		end
	end

	// Drive-side outputs; separator and read gate aligned with the phase register, drive and DMA bits one cycle behind their registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			separatorOn <= 1'h0;
			sectorRead  <= 1'h0;
			dmaMode     <= 1'h0;
			driveOutput <= frd_pkg::DRV_OUT_RST;
		end else begin
			separatorOn <= stateD inside {frd_pkg::ST_SEARCH,
				frd_pkg::ST_DWAIT, frd_pkg::ST_READ};
			sectorRead  <= stateD == frd_pkg::ST_READ && !isRid;
			dmaMode     <= cfgQ[frd_pkg::CFG_DMA];
			driveOutput <= drvOutQ;
		end
	end

	a_irq_result:
	assert property (@(posedge clk_sys) disable iff (rst)
		$rose(stateQ == frd_pkg::ST_RESULT) |-> irqReq)
		else $error("irq not raised at result phase");
	a_delay_len:
	assert property (@(posedge clk_sys) disable iff (rst)
		(stateQ == frd_pkg::ST_SEARCH && $past(stateQ) == frd_pkg::ST_DELAY)
		|-> $past(stateQ, frd_pkg::PRE_CYC) == frd_pkg::ST_DELAY
		&& $past(stateQ, frd_pkg::PRE_CYC + 1) != frd_pkg::ST_DELAY)
		else $error("pre-processing delay has the wrong length");
	a_rid_no_data:
	assert property (@(posedge clk_sys) disable iff (rst)
		(isRid && stateQ != frd_pkg::ST_IDLE) |-> !sectorRead)
		else $error("read-ID transferred data");
	a_abort_write:
	assert property (@(posedge clk_sys) disable iff (rst)
		(isExec && wrData) |=> stateQ == frd_pkg::ST_RESULT
		&& resQ[0][7:6] == frd_pkg::TERM_ABNORMAL)
		else $error("FIFO write did not abort");
	a_two_index:
	assert property (@(posedge clk_sys) disable iff (rst)
		(stateQ == frd_pkg::ST_SEARCH && twoIdx && !hdrValid && !wrData
		&& isRid) |=> resQ[1][frd_pkg::FB_MISS_MRK] && resQ[0][6])
		else $error("missing mark not flagged");
	a_skip_mark:
	assert property (@(posedge clk_sys) disable iff (rst)
		(stateQ == frd_pkg::ST_DWAIT && dataFound && !dataDeleted
		&& !dataMissing && !wrData && cmdQ[0][frd_pkg::OP_BYPASS])
		|=> stateQ == frd_pkg::ST_ADV && fcQ[frd_pkg::FC_CTRL_MRK])
		else $error("normal sector not skipped");
	a_stop_mark:
	assert property (@(posedge clk_sys) disable iff (rst)
		(stateQ == frd_pkg::ST_DWAIT && dataFound && !dataDeleted
		&& !dataMissing && !wrData && !cmdQ[0][frd_pkg::OP_BYPASS])
		|=> stateQ == frd_pkg::ST_READ && stopQ)
		else $error("normal sector not read with stop");
	a_next_sector:
	assert property (@(posedge clk_sys) disable iff (rst)
		(advance && curQ.sector != cmdQ[frd_pkg::CB_LAST])
		|=> curQ.sector == $past(curQ.sector) + 8'h01)
		else $error("sector did not advance by one");
	a_end_normal:
	assert property (@(posedge clk_sys) disable iff (rst)
		(stateQ == frd_pkg::ST_ADV && endStbQ && !wrData)
		|=> resQ[0][7:6] == frd_pkg::TERM_NORMAL ##1 irqReq)
		else $error("transfer end not normal termination");
	a_result_done:
	assert property (@(posedge clk_sys) disable iff (rst)
		(stateQ == frd_pkg::ST_RESULT && rdData
		&& resIdxQ == resLenQ - 3'h1) |=> stateQ == frd_pkg::ST_IDLE)
		else $error("no return to idle after last result");
endmodule : frd_core
`default_nettype wire

// File: inc/frd_pkg.sv
// Constants and types shared by the deleted-data and read-ID sequencer
package frd_pkg;
	// Pre-processing delay before the separator starts
	localparam int unsigned CLK_MHZ      = 125;
	localparam int unsigned PRE_DELAY_NS = 2000;
	localparam int unsigned PRE_CYC      = (PRE_DELAY_NS * CLK_MHZ + 999) / 1000;

	// Register indices; byte address is four times the index
	localparam logic [3:0] IDX_DRV_OUT = 4'h2;
	localparam logic [3:0] IDX_CONFIG  = 4'h3;
	localparam logic [3:0] IDX_STATUS  = 4'h4;
	localparam logic [3:0] IDX_FIFO    = 4'h5;
	localparam logic [7:0] DRV_OUT_RST = 8'h00;
	localparam logic [7:0] CONFIG_RST  = 8'h00;
	localparam int         CFG_DMA     = 0;

	// Opcode patterns and masks
	localparam logic [7:0] OPC_RDD      = 8'h0C;
	localparam logic [7:0] OPC_RDD_MASK = 8'h1F;
	localparam logic [7:0] OPC_RID      = 8'h0A;
	localparam logic [7:0] OPC_RID_MASK = 8'hBF;

	// Opcode and select byte fields
	localparam int OP_MULTI_TRACK = 7;
	localparam int OP_BYPASS      = 5;
	localparam int SEL_HEAD       = 2;

	// Command byte positions and lengths
	localparam int         CB_TRACK = 2;
	localparam int         CB_HEAD  = 3;
	localparam int         CB_SECT  = 4;
	localparam int         CB_SIZE  = 5;
	localparam int         CB_LAST  = 6;
	localparam logic [3:0] RDD_LAST = 4'h8;
	localparam logic [3:0] RID_LAST = 4'h1;
	localparam logic [2:0] RES_LEN  = 3'h7;
	localparam logic [2:0] BAD_LEN  = 3'h1;

	// Termination codes and status flag positions
	localparam logic [1:0] TERM_NORMAL   = 2'h0;
	localparam logic [1:0] TERM_ABNORMAL = 2'h1;
	localparam logic [1:0] TERM_INVALID  = 2'h2;
	localparam int FB_END_TRK  = 7;
	localparam int FB_CRC      = 5;
	localparam int FB_OVERRUN  = 4;
	localparam int FB_NO_DATA  = 2;
	localparam int FB_MISS_MRK = 0;
	localparam int FC_CTRL_MRK = 6;
	localparam int FC_DATA_CRC = 5;

	// Status register bits
	localparam int SR_READY   = 7;
	localparam int SR_TO_HOST = 6;
	localparam int SR_EXEC    = 5;
	localparam int SR_BUSY    = 4;
	localparam int SR_IRQ     = 0;

	// Sector ID header fields
	typedef struct packed {
		logic [7:0] track;
		logic [7:0] head;
		logic [7:0] sector;
		logic [7:0] size;
	} frd_id_s;

	// Sequencer phases
	typedef enum logic [7:0] {
		ST_IDLE   = 8'h01,
		ST_CMD    = 8'h02,
		ST_DELAY  = 8'h04,
		ST_SEARCH = 8'h08,
		ST_DWAIT  = 8'h10,
		ST_READ   = 8'h20,
		ST_ADV    = 8'h40,
		ST_RESULT = 8'h80
	} frd_state_e;
endpackage : frd_pkg

// File: logic/frd_next_id.sv
// Next sector ID reported after a sector run ends, normally or at the end of the track
`timescale 1ns/1ps
`default_nettype none
module frd_next_id (
	input  wire logic             multiTrack,
	input  wire logic             headBit,
	input  wire logic [7:0]       lastSector,
	input  wire frd_pkg::frd_id_s cur,
	output var  frd_pkg::frd_id_s nxt
);
	// Sector plus one, or wrap to the next side or track
	always_comb begin
		nxt = cur;
		if (cur.sector != lastSector) begin
			nxt.sector = cur.sector + 8'h01;
		end else begin
			nxt.sector = 8'h01;
			if (multiTrack && !headBit) begin
				nxt.head = 8'h01;
			end else begin
				nxt.track = cur.track + 8'h01;
				if (multiTrack) begin
					nxt.head = 8'h00;
				end
			end
		end
	end
endmodule : frd_next_id
`default_nettype wire

// File: logic/frd_index_watch.sv
// Counts index pulses seen during one header search
`timescale 1ns/1ps
`default_nettype none
module frd_index_watch (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic clear,
	input  wire logic indexPulse,
	output logic      twoSeen
);
	logic [1:0] cntQ;

	// Saturating count, held at zero outside a search
	always_ff @(posedge clk_sys) begin
		if (rst || clear) begin
			cntQ <= 2'h0;
		end else if (indexPulse && cntQ != 2'h2) begin
			cntQ <= cntQ + 2'h1;
		end
	end

	assign twoSeen = (cntQ == 2'h2);
endmodule : frd_index_watch
`default_nettype wire

// File: dv/frd_drive_model.sv
// Behavioural drive: rotating ID headers, data marks and index pulses
`timescale 1ns/1ps
`default_nettype none
module frd_drive_model (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             separatorOn,
	input  wire logic             sectorRead,
	input  wire logic             noDisk,
	input  wire logic             endEn,
	input  wire logic [7:0]       delMask,
	input  wire frd_pkg::frd_id_s base,
	output logic                  indexPulse,
	output logic                  hdrValid,
	output var frd_pkg::frd_id_s  hdr,
	output logic                  dataFound,
	output logic                  dataDeleted,
	output logic                  sectorDone,
	output logic                  transferEndStrobe
);
	logic [4:0] cnt;
	logic [7:0] sec;

	// One sector passes every 32 cycles; idle lines toggle, never hold
	always_ff @(posedge clk_sys) begin
		hdrValid <= 1'b0;
		dataFound <= 1'b0;
		sectorDone <= 1'b0;
		indexPulse <= 1'b0;
		transferEndStrobe <= 1'b0;
		hdr <= ~hdr;
		dataDeleted <= ~dataDeleted;
		cnt <= cnt + 5'h01;
		if (rst) begin
			cnt <= 5'h00;
			sec <= base.sector;
			hdr <= '0;
			dataDeleted <= 1'b0;
		end else if (separatorOn) begin
			if (cnt == 5'h08) begin
				indexPulse <= noDisk;
				hdrValid <= !noDisk;
				hdr <= {base.track, base.head, sec, base.size};
				sec <= sec + 8'h01;
			end
			// Data mark type of the sector whose header just passed
			if (cnt == 5'h0C) begin
				dataFound <= !noDisk;
				dataDeleted <= delMask[sec[2:0] - 3'h1];
			end
			if (cnt == 5'h14) transferEndStrobe <= endEn && sectorRead;
			if (cnt == 5'h18) sectorDone <= sectorRead;
		end
	end
endmodule : frd_drive_model
`default_nettype wire

// File: dv/test_frd_core.sv
// Self-checking bench for the deleted-data and read-ID sequencer
`timescale 1ns/1ps
`default_nettype none
module test_frd_core;
	logic             clk_sys, rst, req, we, load, noDisk, endEn, sawRead;
	logic [3:0]       adr, sel;
	logic [31:0]      datW, datR;
	logic [7:0]       delMask, q, drvOut;
	logic [7:0]       res [7];
	frd_pkg::frd_id_s base, hdr;
	logic             ack, idx, hv, df, dd, sd, endStb, sepOn, secRd, dma, irq;
	int               failures, n_tests;

	frd_core u_dut (.clk_sys(clk_sys), .rst(rst), .cyc_i(req), .stb_i(req),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR),
		.ack_o(ack), .indexPulse(idx), .hdrValid(hv), .hdr(hdr),
		.hdrCrcErr(1'b0), .dataFound(df), .dataDeleted(dd),
		.dataMissing(1'b0), .sectorDone(sd), .dataCrcErr(1'b0),
		.overrun(1'b0), .transferEndStrobe(endStb), .separatorOn(sepOn),
		.sectorRead(secRd), .dmaMode(dma), .driveOutput(drvOut),
		.irqReq(irq));
	frd_drive_model u_drive (.clk_sys(clk_sys), .rst(rst || load),
		.separatorOn(sepOn), .sectorRead(secRd), .noDisk(noDisk),
		.endEn(endEn), .delMask(delMask), .base(base), .indexPulse(idx),
		.hdrValid(hv), .hdr(hdr), .dataFound(df), .dataDeleted(dd),
		.sectorDone(sd), .transferEndStrobe(endStb));

	// Clock and sector-read watcher
	always #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (rst || load) sawRead <= 1'b0;
		else if (secRd === 1'b1) sawRead <= 1'b1;
	end

	task automatic test_done;
		if (failures == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : test_done

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Classic bus cycle: hold the request until ack is sampled high
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		int i;
		req <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'h1;
		datW <= {24'h000000, d};
		i = 0;
		do begin
			@(posedge clk_sys);
			i++;
		end while (ack !== 1'b1 && i < 20);
		if (ack !== 1'b1) begin
			failures++;
			test_done();
		end
		q = datR[7:0];
		req <= 1'b0;
		we <= 1'b0;
		@(posedge clk_sys);
	endtask : wb

	task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
		wb(1'b0, a, 8'h00);
		chk(q, exp);
	endtask : rdchk

	task automatic fifo(input logic [7:0] d);
		wb(1'b1, frd_pkg::IDX_FIFO, d);
	endtask : fifo

	// Loads a fresh disk image into the drive model
	task automatic disk(input frd_pkg::frd_id_s b, input logic [7:0] m,
		input logic nd, input logic t);
		base <= b;
		delMask <= m;
		noDisk <= nd;
		endEn <= t;
		load <= 1'b1;
		@(posedge clk_sys);
		load <= 1'b0;
	endtask : disk

	task automatic rdd(input logic [7:0] op, sl, trk, headNo, sc, lastSec);
		logic [7:0] b [9];
		b = '{op, sl, trk, headNo, sc, 8'h02, lastSec, 8'h1B, 8'hFF};
		for (int k = 0; k < 9; k++) fifo(b[k]);
	endtask : rdd

	// Waits for the interrupt, then drains the seven result bytes
	task automatic results;
		int i;
		i = 0;
		while (irq !== 1'b1 && i < 3000) begin
			@(posedge clk_sys);
			i++;
		end
		if (irq !== 1'b1) begin
			failures++;
			test_done();
		end
		for (int k = 0; k < 7; k++) begin
			fifo_rd(k);
		end
		chk({7'h00, irq}, 8'h00);
		rdchk(frd_pkg::IDX_STATUS, 8'h80);
	endtask : results

	task automatic fifo_rd(input int k);
		wb(1'b0, frd_pkg::IDX_FIFO, 8'h00);
		res[k] = q;
	endtask : fifo_rd

	task automatic expect7(input logic [7:0] e [7]);
		for (int k = 0; k < 7; k++) chk(res[k], e[k]);
	endtask : expect7

	// Main sequence
	initial begin
		clk_sys = 1'b0;
		rst = 1'b1;
		{req, we, load, noDisk, endEn} = 5'h00;
		{adr, sel, datW, delMask, base} = '0;
		failures = 0;
		n_tests = 0;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		// Register reset values, unmapped index, mode bit
		rdchk(frd_pkg::IDX_DRV_OUT, frd_pkg::DRV_OUT_RST);
		rdchk(frd_pkg::IDX_CONFIG, frd_pkg::CONFIG_RST);
		rdchk(4'hF, 8'h00);
		wb(1'b1, frd_pkg::IDX_CONFIG, 8'h01);
		chk({7'h00, dma}, 8'h01);
		wb(1'b1, frd_pkg::IDX_CONFIG, 8'h00);
		chk({7'h00, dma}, 8'h00);
		// ID read: delay, motor on meanwhile, first header returned
		disk('{8'h05, 8'h00, 8'h03, 8'h02}, 8'h00, 1'b0, 1'b0);
		fifo(8'h4A);
		fifo(8'h00);
		wb(1'b1, frd_pkg::IDX_DRV_OUT, 8'h1C);
		chk(drvOut, 8'h1C);
		repeat (frd_pkg::PRE_CYC - 20) @(posedge clk_sys);
		chk({7'h00, sepOn}, 8'h00);
		results;
		expect7('{8'h00, 8'h00, 8'h00, 8'h05, 8'h00, 8'h03, 8'h02});
		chk({7'h00, sawRead}, 8'h00);
		// ID read with no disk: two index pulses
		disk('{8'h05, 8'h00, 8'h03, 8'h02}, 8'h00, 1'b1, 1'b0);
		fifo(8'h4A);
		fifo(8'h00);
		results;
		chk(res[0], 8'h40);
		chk(res[1], 8'h01);
		// ID read with no disk, aborted by a FIFO write during the delay
		disk('{8'h05, 8'h00, 8'h03, 8'h02}, 8'h00, 1'b1, 1'b0);
		fifo(8'h4A);
		fifo(8'h00);
		fifo(8'h00);
		results;
		chk(res[0], 8'h40);
		// Skip clear: deleted, deleted, then a normal sector stops
		disk('{8'h05, 8'h00, 8'h01, 8'h02}, 8'h06, 1'b0, 1'b0);
		rdd(8'h4C, 8'h00, 8'h05, 8'h00, 8'h01, 8'h05);
		results;
		chk(res[2], 8'h40);
		chk(res[3], 8'h05);
		expect7('{8'h00, 8'h00, 8'h40, 8'h05, 8'h00, 8'h04, 8'h02});
		// Skip set: normal sector passed over, run ends at last sector
		disk('{8'h05, 8'h00, 8'h01, 8'h02}, 8'h0C, 1'b0, 1'b0);
		rdd(8'h6C, 8'h00, 8'h05, 8'h00, 8'h01, 8'h03);
		results;
		expect7('{8'h40, 8'h80, 8'h40, 8'h06, 8'h00, 8'h01, 8'h02});
		// Unwanted header skipped, transfer end strobe ends sector 2
		disk('{8'h05, 8'h00, 8'h01, 8'h02}, 8'hFE, 1'b0, 1'b1);
		rdd(8'hCC, 8'h00, 8'h05, 8'h00, 8'h02, 8'h05);
		results;
		expect7('{8'h00, 8'h00, 8'h00, 8'h05, 8'h00, 8'h03, 8'h02});
		// Multi-track on side 1 at the last sector: next track, side 0
		disk('{8'h05, 8'h01, 8'h01, 8'h02}, 8'h02, 1'b0, 1'b0);
		rdd(8'hCC, 8'h04, 8'h05, 8'h01, 8'h01, 8'h01);
		results;
		expect7('{8'h44, 8'h80, 8'h00, 8'h06, 8'h00, 8'h01, 8'h02});
		// Multi-track side 0 at the last sector, strobe ends it: side 1
		disk('{8'h05, 8'h00, 8'h01, 8'h02}, 8'h02, 1'b0, 1'b1);
		rdd(8'hCC, 8'h00, 8'h05, 8'h00, 8'h01, 8'h01);
		results;
		expect7('{8'h00, 8'h00, 8'h00, 8'h05, 8'h01, 8'h01, 8'h02});
		// Deleted-data read aborted with no disk keeps the commanded ID
		disk('{8'h05, 8'h00, 8'h01, 8'h02}, 8'h00, 1'b1, 1'b0);
		rdd(8'h4C, 8'h00, 8'h07, 8'h00, 8'h04, 8'h09);
		fifo(8'h00);
		results;
		expect7('{8'h40, 8'h00, 8'h00, 8'h07, 8'h00, 8'h04, 8'h02});
		test_done();
	end
endmodule : test_frd_core
`default_nettype wire
